// ===== design/sesp_pkg.sv
// shared constants and state types for the serial eeprom slave port
package sesp_pkg;

  // memory geometry
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned PAGE_W = 7;
  localparam int unsigned PAGE_BYTES = 128;
  localparam int unsigned MEM_BYTES = 16384;

  // slave address byte layout
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam int unsigned DEV_TYPE_LSB = 4;
  localparam int unsigned STRAP_LSB = 1;
  localparam int unsigned RW_BIT = 0;

  // bit slot counter: slots 0..7 carry data, slot 8 is the acknowledge
  localparam logic [3:0] LAST_DATA_SLOT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // reset address value and default programming wait length
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
  localparam logic [15:0] PROG_CYCLES_DEF = 16'h0032;

  typedef enum logic [2:0] {
    SESP_L_IDLE    = 3'b000,
    SESP_L_DEVADDR = 3'b001,
    SESP_L_ADDRHI  = 3'b010,
    SESP_L_ADDRLO  = 3'b011,
    SESP_L_WDATA   = 3'b100,
    SESP_L_RDATA   = 3'b101
  } sesp_link_e;

  typedef enum logic [1:0] {
    SESP_P_IDLE  = 2'b00,
    SESP_P_WRITE = 2'b01,
    SESP_P_WAIT  = 2'b10
  } sesp_prog_e;

endpackage : sesp_pkg

// ===== design/sesp_serial_eeprom_slave_port.sv
// two-wire slave front end with page buffer and 16k x 8 array
//
// Operation
// RL1: master starts transfers only on idle bus
// RL2: sda fall while scl high starts frame
// RL3: sda rise while scl high stops frame
// RL4: sda changes only while scl low
// RL5: one bit per pulse, msb first, ack
// RL6: acknowledge matching address and every received byte
// RL7: match 1010 plus three strap levels
// RL8: address lsb one reads, zero writes
// RL9: master recovers bus by clocking then start
// RL10: standby when idle, after reads, after programming
// RL11: stop after write data launches programming
// RL12: no acknowledge at all while programming runs
// RL13: page write buffers up to 128 bytes
// RL14: write increments low seven address bits only
// RL15: page overflow overwrites earlier buffered bytes
// RL16: whole page programmed in one cycle
// RL17: current read returns byte at counter
// RL18: master nacks then stops to end read
// RL19: read increment carries across page boundaries
// RL20: dummy write sets address, repeated start reads
// RL21: master ack fetches next byte, nack ends
// RL22: counter wraps to zero past array top
// RL23: counter spans all 16384 locations
// RL24: write inhibit high blocks all programming
// RL25: floating straps read as zero
// RL26: mismatched address released, ignored until start
// RL27: mid-byte start or stop aborts without programming; a stop after a complete data byte still programs the buffered bytes
`timescale 1ns/10ps
module sesp_serial_eeprom_slave_port #(
  parameter logic [15:0] PROG_CYCLES = sesp_pkg::PROG_CYCLES_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_addr_strap_bit0,
  input wire logic i_addr_strap_bit1,
  input wire logic i_addr_strap_bit2,
  input wire logic i_write_inhibit,
  output logic o_standby,
  output logic o_prog_busy
);

  // array: written only by the programming engine, read by the link side
  logic [7:0] mem_q [sesp_pkg::MEM_BYTES];
  logic [7:0] page_buf_q [sesp_pkg::PAGE_BYTES];
  logic [sesp_pkg::PAGE_BYTES-1:0] page_mask_q;

  // ---------------- condition detectors, clocked by sda edges ----------------
  // the link flops clear asynchronously: scl may stand still during reset
  logic start_tog_q;
  logic stop_tog_q;
  logic commit_tog_q;
  logic frame_tog_q;
  logic start_seen_q;
  logic stop_seen_q;
  logic wr_pending_q;
  logic stop_pend;

  assign stop_pend = stop_tog_q ^ stop_seen_q;

  always_ff @(negedge i_sda_in or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      start_tog_q <= 1'b0;
      frame_tog_q <= 1'b0;
    end else if (i_scl) begin
      start_tog_q <= ~start_tog_q; // see RL2
      frame_tog_q <= ~stop_tog_q;
    end
  end

  // commit only on the first stop after a complete data byte
  always_ff @(posedge i_sda_in or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stop_tog_q <= 1'b0;
      commit_tog_q <= 1'b0;
    end else if (i_scl) begin
      stop_tog_q <= ~stop_tog_q; // see RL3
      if (wr_pending_q && !stop_pend) begin
        commit_tog_q <= ~commit_tog_q; // see RL11 see RL27
      end
    end
  end

  // ---------------- link side, clocked by scl ----------------
  logic [2:0] strap_s1_q;
  logic [2:0] strap_s2_q;
  logic done_s1_q;
  logic done_s2_q;
  logic done_q;
  sesp_pkg::sesp_link_e st_q;
  sesp_pkg::sesp_link_e st_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] rx_sh_q;
  logic [7:0] tx_q;
  logic ack_q;
  logic rw_q;
  logic [7:0] addr_hi_q;
  logic [sesp_pkg::ADDR_W-1:0] addr_q;
  logic sda_oe_q;

  wire start_new = start_tog_q ^ start_seen_q;
  wire link_busy = commit_tog_q ^ done_s2_q;
  wire [7:0] byte_in = {rx_sh_q[6:0], i_sda_in};
  wire last_bit = (st_q != sesp_pkg::SESP_L_IDLE) && (cnt_q == sesp_pkg::LAST_DATA_SLOT);
  wire ack_slot = (st_q != sesp_pkg::SESP_L_IDLE) && (cnt_q == sesp_pkg::ACK_SLOT);
  wire type_ok = byte_in[7:sesp_pkg::DEV_TYPE_LSB] == sesp_pkg::DEV_TYPE;
  wire strap_ok = byte_in[sesp_pkg::DEV_TYPE_LSB-1:sesp_pkg::STRAP_LSB] == strap_s2_q;
  // busy devices stay silent even to their own address
  wire dev_match = type_ok && strap_ok && !link_busy; // see RL7 see RL12
  wire in_dev = st_q == sesp_pkg::SESP_L_DEVADDR;
  wire in_wdata = st_q == sesp_pkg::SESP_L_WDATA;
  wire in_rdata = st_q == sesp_pkg::SESP_L_RDATA;
  wire wr_byte = last_bit && in_wdata;
  wire set_addr = last_bit && (st_q == sesp_pkg::SESP_L_ADDRLO);
  // fetch at the ack slot: after a read address ack, or after the master acks
  wire fetch = ack_slot && ((in_dev && ack_q && rw_q) || (in_rdata && !i_sda_in)); // see RL21
  wire [sesp_pkg::PAGE_W-1:0] page_off = addr_q[sesp_pkg::PAGE_W-1:0];
  wire [sesp_pkg::PAGE_W-1:0] page_off_inc = page_off + 7'h01;
  wire [sesp_pkg::ADDR_W-1:0] addr_inc = addr_q + 14'h0001;
  wire [sesp_pkg::ADDR_W-1:0] addr_wr_next = {addr_q[13:7], page_off_inc}; // see RL14
  wire [sesp_pkg::ADDR_W-1:0] addr_set = {addr_hi_q[5:0], byte_in};
  wire ack_now = in_dev ? dev_match : !in_rdata; // see RL6

  // all three strap bits are compared in the address match, none are don't-care
  always_comb begin
    st_d = st_q;
    if (start_new) begin
      st_d = sesp_pkg::SESP_L_DEVADDR; // see RL27
    end else if (ack_slot) begin
      unique case (st_q)
        sesp_pkg::SESP_L_DEVADDR: begin
          if (!ack_q) begin
            st_d = sesp_pkg::SESP_L_IDLE; // see RL26
          end else if (rw_q) begin
            st_d = sesp_pkg::SESP_L_RDATA; // see RL8 see RL17
          end else begin
            st_d = sesp_pkg::SESP_L_ADDRHI;
          end
        end
        sesp_pkg::SESP_L_ADDRHI: st_d = sesp_pkg::SESP_L_ADDRLO;
        sesp_pkg::SESP_L_ADDRLO: st_d = sesp_pkg::SESP_L_WDATA; // see RL20
        sesp_pkg::SESP_L_WDATA: st_d = sesp_pkg::SESP_L_WDATA; // see RL13
        sesp_pkg::SESP_L_RDATA: begin
          st_d = i_sda_in ? sesp_pkg::SESP_L_IDLE : sesp_pkg::SESP_L_RDATA; // see RL18
        end
        default: st_d = sesp_pkg::SESP_L_IDLE;
      endcase
    end
  end

  always_comb begin
    if (start_new) begin
      cnt_d = 4'h1;
    end else if (st_q == sesp_pkg::SESP_L_IDLE || ack_slot) begin
      cnt_d = 4'h0;
    end else begin
      cnt_d = cnt_q + 4'h1; // see RL5
    end
  end

  always_ff @(posedge i_scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      start_seen_q <= 1'b0;
      stop_seen_q <= 1'b0;
    end else begin
      // a floating strap is pulled low at the pin, so zero is its level
      strap_s1_q <= {i_addr_strap_bit2, i_addr_strap_bit1, i_addr_strap_bit0}; // see RL25
      strap_s2_q <= strap_s1_q;
      done_s1_q <= done_q;
      done_s2_q <= done_s1_q;
      start_seen_q <= start_tog_q;
      stop_seen_q <= stop_tog_q;
    end
  end

  // sda is sampled on the rising edge, while it is held stable
  always_ff @(posedge i_scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= sesp_pkg::SESP_L_IDLE;
      cnt_q <= 4'h0;
      rx_sh_q <= 8'h00;
      ack_q <= 1'b0;
      rw_q <= 1'b0;
    end else begin
      st_q <= st_d; // see RL2
      cnt_q <= cnt_d;
      rx_sh_q <= start_new ? {7'h00, i_sda_in} : byte_in; // see RL4
      if (last_bit) begin
        ack_q <= ack_now;
      end
      if (last_bit && in_dev) begin
        rw_q <= byte_in[sesp_pkg::RW_BIT];
      end
    end
  end

  always_ff @(posedge i_scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_hi_q <= 8'h00;
      addr_q <= sesp_pkg::ADDR_RST;
      tx_q <= 8'h00;
      wr_pending_q <= 1'b0;
    end else begin
      if (last_bit && st_q == sesp_pkg::SESP_L_ADDRHI) begin
        addr_hi_q <= byte_in;
      end
      if (set_addr) begin
        addr_q <= addr_set; // see RL20 see RL23
      end else if (wr_byte) begin
        addr_q <= addr_wr_next; // see RL14
      end else if (fetch) begin
        addr_q <= addr_inc; // see RL19 see RL22
      end
      if (fetch) begin
        tx_q <= mem_q[addr_q]; // see RL17
      end
      if (start_new) begin
        wr_pending_q <= 1'b0; // see RL27
      end else if (wr_byte) begin
        wr_pending_q <= 1'b1;
      end
    end
  end

  // page buffer: position is the low address bits, so overflow overwrites
  always_ff @(posedge i_scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      page_mask_q <= '0;
    end else if (set_addr) begin
      page_mask_q <= '0;
    end else if (wr_byte) begin
      page_mask_q[page_off] <= 1'b1; // see RL15
    end
  end

  always_ff @(posedge i_scl) begin
    if (wr_byte) begin
      page_buf_q[page_off] <= byte_in; // see RL13 see RL15
    end
  end

  // drive on the falling edge so sda only moves while scl is low
  always_ff @(negedge i_scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sda_oe_q <= 1'b0;
    end else if (start_new) begin
      // a start frees the line before the first address bit arrives
      sda_oe_q <= 1'b0; // see RL27
    end else if (cnt_q == sesp_pkg::ACK_SLOT) begin
      sda_oe_q <= ack_q; // see RL6 see RL4
    end else if (in_rdata) begin
      sda_oe_q <= ~tx_q[~cnt_q[2:0]]; // see RL5
    end else begin
      sda_oe_q <= 1'b0;
    end
  end

  // a stop releases the line at once, before any further scl edge
  assign o_sda_oe = sda_oe_q & ~stop_pend;
  assign o_sda_out = 1'b0;

  // ---------------- programming engine, clocked by i_sys_clk ----------------
  logic commit_s1_q;
  logic commit_s2_q;
  logic frame_s1_q;
  logic frame_s2_q;
  logic wi_s1_q;
  logic wi_s2_q;
  logic done_d;
  sesp_pkg::sesp_prog_e pst_q;
  sesp_pkg::sesp_prog_e pst_d;
  logic [sesp_pkg::PAGE_W-1:0] pidx_q;
  logic [15:0] pwait_q;
  logic standby_q;
  logic prog_busy_q;

  wire in_frame = frame_tog_q ^ stop_tog_q;
  wire commit_req = commit_s2_q ^ done_q;
  wire pidx_last = pidx_q == 7'h7f;
  wire pwait_last = pwait_q == (PROG_CYCLES - 16'h0001);
  wire [sesp_pkg::ADDR_W-1:0] prog_addr = {addr_q[13:7], pidx_q};
  wire prog_wr = (pst_q == sesp_pkg::SESP_P_WRITE) && page_mask_q[pidx_q];
  // inhibited commits never raise busy; it drops with the done toggle, before any ack
  wire prog_busy_d = (commit_s2_q ^ done_d) || (pst_d != sesp_pkg::SESP_P_IDLE);

  always_comb begin
    pst_d = pst_q;
    done_d = done_q;
    unique case (pst_q)
      sesp_pkg::SESP_P_IDLE: begin
        if (commit_req && wi_s2_q) begin
          done_d = commit_s2_q; // see RL24
        end else if (commit_req) begin
          pst_d = sesp_pkg::SESP_P_WRITE; // see RL11
        end
      end
      sesp_pkg::SESP_P_WRITE: begin
        if (pidx_last) begin
          pst_d = sesp_pkg::SESP_P_WAIT;
        end
      end
      sesp_pkg::SESP_P_WAIT: begin
        if (pwait_last) begin
          pst_d = sesp_pkg::SESP_P_IDLE;
          done_d = commit_s2_q; // see RL12
        end
      end
      default: pst_d = sesp_pkg::SESP_P_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      commit_s1_q <= 1'b0;
      commit_s2_q <= 1'b0;
      frame_s1_q <= 1'b0;
      frame_s2_q <= 1'b0;
      wi_s1_q <= 1'b0;
      wi_s2_q <= 1'b0;
    end else begin
      commit_s1_q <= commit_tog_q;
      commit_s2_q <= commit_s1_q;
      frame_s1_q <= in_frame;
      frame_s2_q <= frame_s1_q;
      wi_s1_q <= i_write_inhibit;
      wi_s2_q <= wi_s1_q;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pst_q <= sesp_pkg::SESP_P_IDLE;
      done_q <= 1'b0;
      pidx_q <= 7'h00;
      pwait_q <= 16'h0000;
    end else begin
      pst_q <= pst_d;
      done_q <= done_d;
      pidx_q <= (pst_q == sesp_pkg::SESP_P_WRITE) ? pidx_q + 7'h01 : 7'h00;
      pwait_q <= (pst_q == sesp_pkg::SESP_P_WAIT) ? pwait_q + 16'h0001 : 16'h0000;
    end
  end

  // every buffered byte of the page lands in one pass
  always_ff @(posedge i_sys_clk) begin
    if (prog_wr) begin
      mem_q[prog_addr] <= page_buf_q[pidx_q]; // see RL16
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      standby_q <= 1'b0;
      prog_busy_q <= 1'b0;
    end else begin
      standby_q <= !frame_s2_q && !commit_req && (pst_q == sesp_pkg::SESP_P_IDLE); // see RL10
      prog_busy_q <= prog_busy_d; // see RL24
    end
  end

  assign o_standby = standby_q;
  assign o_prog_busy = prog_busy_q;

endmodule : sesp_serial_eeprom_slave_port

// ===== bench/sesp_chk.sv
// pin-level assertions for the two-wire slave port
`timescale 1ns/10ps
module sesp_chk #(
  parameter logic [15:0] PROG_CYCLES = 16'h0032
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda_in,
  input wire logic i_write_inhibit,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_standby,
  input wire logic o_prog_busy
);
  logic [15:0] busy_cnt_q;
  logic [15:0] busy_cnt_d;
  logic oe_rise_q;
  assign busy_cnt_d = o_prog_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge i_sys_clk) begin
    busy_cnt_q <= i_sys_rst ? 16'h0000 : busy_cnt_d;
  end
  // scl may stand still, so this capture resets asynchronously
  always_ff @(posedge i_scl or posedge i_sys_rst) begin
    oe_rise_q <= i_sys_rst ? 1'b0 : o_sda_oe;
  end
  sequence busy_rise_s;
    $rose(o_prog_busy);
  endsequence
  sequence busy_held_s;
    o_prog_busy [*8];
  endsequence
  AST_OPEN_DRAIN:
  assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) o_sda_out == 1'b0)
    else $error("data output value not low");
  AST_BUSY_NO_ACK:
  assert property (@(posedge i_scl) disable iff (i_sys_rst) o_prog_busy |-> !o_sda_oe)
    else $error("data line pulled while programming");
  AST_BUSY_NO_STANDBY:
  assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) o_prog_busy |-> !o_standby)
    else $error("standby while programming");
  AST_BUSY_HOLD:
  assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) busy_rise_s |=> busy_held_s)
    else $error("programming ended too soon");
  AST_BUSY_LEN:
  assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) $fell(o_prog_busy) |->
    busy_cnt_q >= 16'h007f && busy_cnt_q <= 16'h0088 + PROG_CYCLES)
    else $error("programming length out of range");
  AST_INHIBIT:
  assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) busy_rise_s |->
    !(i_write_inhibit && $past(i_write_inhibit, 4)))
    else $error("programming started while inhibited");
  AST_STANDBY_WAKE:
  assert property (@(posedge i_sys_clk) $fell(i_sys_rst) |-> ##[1:3] o_standby)
    else $error("no standby after reset");
  AST_OE_HIGH_PHASE:
  assert property (@(negedge i_scl) disable iff (i_sys_rst) o_sda_oe == oe_rise_q)
    else $error("data drive changed while clock high");
endmodule : sesp_chk

bind sesp_serial_eeprom_slave_port sesp_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda_in(i_sda_in),
  .i_write_inhibit(i_write_inhibit), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_standby(o_standby), .o_prog_busy(o_prog_busy));

// ===== bench/sesp_master_model.sv
// two-wire bus master; its clock toggles only inside frames
`timescale 1ns/10ps
module sesp_master_model (
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda
);
  logic [8:0] rx;
  event done;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // sda lifted while scl low, so a repeated start never looks like a stop
  task automatic start();
    o_sda = 1'b1;
    #12 o_scl = 1'b1;
    #24 o_sda = 1'b0;
    #24 o_scl = 1'b0;
    // sda must not move in the time step of the scl fall
    #12;
  endtask : start
  // clock out what the slave still drives, then start at the first free bit
  task automatic recover();
    o_sda = 1'b1;
    for (int i = 0; i < 9; i++) begin
      #12 o_scl = 1'b1;
      if (i_sda) break;
      #24 o_scl = 1'b0;
      #12;
    end
    #24 o_sda = 1'b0;
    #24 o_scl = 1'b0;
    #12;
  endtask : recover
  task automatic stop();
    o_sda = 1'b0;
    #12 o_scl = 1'b1;
    #24 o_sda = 1'b1;
    #48;
  endtask : stop
  // nine slots msb first; a one in the last slot leaves the line released
  task automatic xfer(input logic [8:0] d);
    for (int i = 8; i >= 0; i--) begin
      o_sda = d[i];
      #12 o_scl = 1'b1;
      rx[i] = i_sda;
      #24 o_scl = 1'b0;
      #12;
    end
    -> done;
  endtask : xfer
endmodule : sesp_master_model

// ===== bench/sesp_serial_eeprom_slave_port_tb_top.sv
// self-checking bench for the serial eeprom slave port
`timescale 1ns/10ps
module sesp_serial_eeprom_slave_port_tb_top;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b0;
  logic [2:0] strap = 3'h0;
  logic wr_inh = 1'b0;
  logic polling = 1'b0;
  logic scl, sda_m, sda_oe, sda_out, standby, busy;
  logic [7:0] dev;
  logic [7:0] mem [int];
  logic [8:0] exp_q [$];
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  wire logic sda;
  // pulled-up wire: released by both parties reads high
  assign sda = sda_m & ~(sda_oe & ~sda_out);
  always #50 i_sys_clk = ~i_sys_clk;
  sesp_master_model m (.o_scl(scl), .o_sda(sda_m), .i_sda(sda));
  sesp_serial_eeprom_slave_port #(.PROG_CYCLES(16'h0004)) DUT (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda_in(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_addr_strap_bit0(strap[0]),
    .i_addr_strap_bit1(strap[1]), .i_addr_strap_bit2(strap[2]),
    .i_write_inhibit(wr_inh), .o_standby(standby), .o_prog_busy(busy));
  task automatic cmp_slot(input logic [8:0] e, input logic [8:0] s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("Error bus slot expected %h seen %h", e, s);
    end
  endtask : cmp_slot
  task automatic cmp_flag(input string what, input logic e, input logic s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %b seen %b", what, e, s);
    end
  endtask : cmp_flag
  task automatic wbyte(input logic [7:0] b, input logic ack);
    exp_q.push_back({b, ~ack});
    m.xfer({b, 1'b1});
  endtask : wbyte
  task automatic rbyte(input logic [7:0] e, input logic mack);
    exp_q.push_back({e, ~mack});
    m.xfer({8'hff, ~mack});
  endtask : rbyte
  task automatic addr(input logic [13:0] a);
    m.start();
    wbyte(dev, 1'b1);
    wbyte({2'b00, a[13:8]}, 1'b1);
    wbyte(a[7:0], 1'b1);
  endtask : addr
  task automatic poll(input logic exp_busy);
    int n;
    n = 0;
    polling = 1'b1;
    repeat (10) @(negedge i_sys_clk);
    cmp_flag("busy", exp_busy, busy);
    do begin
      m.start();
      m.xfer({dev, 1'b1});
      n++;
    end while (m.rx[0] !== 1'b0 && n < 80);
    m.stop();
    polling = 1'b0;
    cmp_flag("poll ack", 1'b0, m.rx[0]);
    cmp_flag("poll refused", exp_busy, 1'(n > 1));
  endtask : poll
  task automatic wpage(input logic [13:0] a, input int n, input logic inh);
    logic [7:0] b;
    addr(a);
    for (int k = 0; k < n; k++) begin
      b = 8'($urandom);
      wbyte(b, 1'b1);
      if (!inh) mem[{a[13:7], 7'(a[6:0] + k)}] = b;
    end
    m.stop();
    poll(!inh);
    $display("test page write at %h done", a);
  endtask : wpage
  task automatic rseq(input logic [13:0] a, input int n, input logic rnd);
    if (rnd) addr(a);
    m.start();
    wbyte(dev | 8'h01, 1'b1);
    for (int k = 0; k < n; k++) rbyte(mem[14'(a + k)], k < n - 1);
    m.stop();
    repeat (5) @(negedge i_sys_clk);
    cmp_flag("standby", 1'b1, standby);
    $display("test read at %h done", a);
  endtask : rseq
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  always @(m.done) begin
    if (!polling) cmp_slot(exp_q.pop_front(), m.rx);
  end
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'hc1c7));
    // a real rising edge, so the edge-clocked link flops see the reset
    #1 i_sys_rst = 1'b1;
    repeat (12) @(negedge i_sys_clk);
    strap = 3'($urandom);
    i_sys_rst = 1'b0;
    dev = {4'ha, strap, 1'b0};
    repeat (3) @(negedge i_sys_clk);
    cmp_flag("standby", 1'b1, standby);
    for (int k = 1; k < 8; k++) begin
      m.start();
      wbyte(dev ^ (8'h01 << k), 1'b0);
    end
    wbyte(dev, 1'b0);
    m.stop();
    $display("test address match done");
    wpage(14'h05fe, 4, 1'b0);
    wpage(14'h0540, 130, 1'b0);
    // abort a read while the slave drives mid-byte, then read on from the counter
    addr(14'h0510);
    m.start();
    wbyte(dev | 8'h01, 1'b1);
    rbyte(mem[14'h0510], 1'b1);
    m.recover();
    wbyte(dev | 8'h01, 1'b1);
    rbyte(mem[14'h0512], 1'b0);
    m.stop();
    $display("test bus recovery done");
    rseq(14'h057f, 2, 1'b1);
    rseq(14'h0581, 1, 1'b0);
    wpage(14'h3fff, 1, 1'b0);
    wpage(14'h0000, 1, 1'b0);
    rseq(14'h3fff, 2, 1'b1);
    @(negedge i_sys_clk);
    wr_inh = 1'b1;
    wpage(14'h0580, 1, 1'b1);
    @(negedge i_sys_clk);
    wr_inh = 1'b0;
    rseq(14'h0580, 1, 1'b1);
    summarize();
  end
endmodule : sesp_serial_eeprom_slave_port_tb_top
